/* File: hdl/ijp_pkg.sv */
// Shared constants, field layouts and state types for the ink-jet station block
package ijp_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;   // System clock rate
  localparam int unsigned DISC_S      = 15;           // Carrier-loss disconnect, seconds
  localparam int unsigned DISC_CYC    = DISC_S * CLK_HZ;
  localparam int unsigned HOLD_MS     = 8;            // Character hold time, milliseconds
  localparam int unsigned HOLD_CYC    = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned BAUD        = 1200;         // Serial line rate, bits per second
  localparam int unsigned BIT_CYC     = CLK_HZ / BAUD;

  // ---------------------------------------------------------------------------
  // Widths and codes
  // ---------------------------------------------------------------------------
  localparam int unsigned CODE_W      = 7;            // Character code bits
  localparam int unsigned STEP_W      = 3;            // Subroutine step index bits
  localparam int unsigned STEPS       = 8;            // Memory words per character
  localparam int unsigned MEM_AW      = CODE_W + STEP_W;
  localparam int unsigned MEM_DEPTH   = 1024;
  localparam int unsigned TRACE_W     = 10;
  localparam int unsigned COLS        = 40;           // Column positions on a line
  localparam int unsigned COL_W       = 6;
  localparam int unsigned GROUPS      = 5;            // Column group selects
  localparam int unsigned BIN_W       = 3;            // Binary column selects
  localparam logic [CODE_W-1:0] LF_CODE  = 7'h0a;     // Line-feed code
  localparam logic [COL_W-1:0]  COL_LAST = 6'h27;     // Last column, 39

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;             // Control
  localparam logic [7:0] A_STAT  = 8'h04;             // Live status
  localparam logic [7:0] A_IRQS  = 8'h08;             // Sticky events, write one to clear
  localparam logic [7:0] A_IRQM  = 8'h0c;             // Event mask
  localparam logic [7:0] A_MADR  = 8'h10;             // Character memory address
  localparam logic [7:0] A_MDAT  = 8'h14;             // Character memory data
  localparam int unsigned C_SER  = 0;                 // Control: serial front end selected
  localparam int unsigned C_DISC = 1;                 // Control: discrete calling option
  localparam int unsigned CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam int unsigned E_ON    = 0;                // Event: printer turned on
  localparam int unsigned E_OFF   = 1;                // Event: printer turned off
  localparam int unsigned E_FAULT = 2;                // Event: ready dropped
  localparam int unsigned E_CHAR  = 3;                // Event: character finished
  localparam int unsigned E_LOST  = 4;                // Event: character arrived while busy
  localparam int unsigned EV_W    = 5;

  // ---------------------------------------------------------------------------
  // Carriers and state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] vpos;         // Vertical position
    logic [2:0] hpos;         // Horizontal position
    logic       jet_up;       // Jet up / down
    logic       half_right;   // Right half of column
    logic       vamp_second;  // Second vertical amplifier set
  } ijp_trace_t;

  typedef struct packed {
    logic [GROUPS-1:0] group;  // One-hot group select
    logic [BIN_W-1:0]  bin;    // Binary select
    logic [BIN_W-1:0]  bin_n;  // Complement of binary select
  } ijp_col_t;

  typedef enum logic [1:0] {CH_IDLE, CH_STEP, CH_SPACE} ijp_ch_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ijp_rx_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0]   irq_stat;
    logic [EV_W-1:0]   irq_mask;
    logic [MEM_AW-1:0] mem_adr;
    logic [31:0]       rdata;
    logic              irq;
    logic              ready;
    logic              on;
    logic              answer;
    logic              carrier_prev;
    logic [31:0]       disc_cnt;
    ijp_rx_t           rx;
    logic [31:0]       rx_cnt;
    logic [STEP_W-1:0] rx_bit;
    logic [CODE_W-1:0] rx_sh;
    logic [CODE_W-1:0] code;
    ijp_ch_t           ch;
    logic [STEP_W-1:0] step;
    logic [31:0]       step_cnt;
    ijp_trace_t        trace;
    logic [COL_W-1:0]  column;
    ijp_col_t          col;
    logic              line_feed;
  } ijp_state_t;

endpackage

/* File: hdl/ijp_station.sv */
// Station control, front ends and character path of the ink-jet printer
`timescale 1ns/10ps

module ijp_station #(
  parameter int unsigned DISC_CYC = ijp_pkg::DISC_CYC,  // Carrier-loss cycles
  parameter int unsigned HOLD_CYC = ijp_pkg::HOLD_CYC,  // Character hold cycles
  parameter int unsigned BIT_CYC  = ijp_pkg::BIT_CYC    // Serial bit cycles
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  // Register port
  input  wire logic [7:0]                  addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [31:0]                 rdata_o,
  output logic                             irq_o,
  // Station conditions and modem
  input  wire logic                        interlock_ok_i,
  input  wire logic                        paper_thread_ok_i,
  input  wire logic                        hv_fault_i,
  input  wire logic                        feed_fault_i,
  input  wire logic                        paper_fault_i,
  input  wire logic                        carrier_i,
  input  wire logic                        ring_i,
  input  wire logic                        auto_answer_i,
  input  wire logic                        data_key_i,
  input  wire logic                        voice_mode_i,
  input  wire logic                        tone_done_i,
  output logic                             ready_o,
  output logic                             printing_on_o,
  output logic                             answer_o,
  output logic                             motors_o,
  output logic                             hv_on_o,
  output logic                             on_lamp_o,
  output logic                             superv_o,
  // Front ends
  input  wire logic                        serial_front_end_i,
  input  wire logic [ijp_pkg::CODE_W-1:0]  parallel_front_end_i,
  input  wire logic                        par_strobe_i,
  // Printer drive
  output ijp_pkg::ijp_col_t                col_o,
  output ijp_pkg::ijp_trace_t              trace_o,
  output logic                             line_feed_o
);

  // Cycles that one memory word is shown; eight of them make the hold
  localparam int unsigned STEP_CYC = HOLD_CYC / ijp_pkg::STEPS;

  ijp_pkg::ijp_state_t st_q;   // All registered state except cmem and hold_cnt
  ijp_pkg::ijp_state_t st_d;   // Its next value

  // Character subroutine memory, loaded by software
  logic [ijp_pkg::TRACE_W-1:0] cmem [ijp_pkg::MEM_DEPTH];

  // ---------------------------------------------------------------------------
  // Character memory write port
  // ---------------------------------------------------------------------------
  // Kept out of the state struct: a memory that size belongs in RAM
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && addr_i == ijp_pkg::A_MDAT) begin
      cmem[st_q.mem_adr] <= wdata_i[ijp_pkg::TRACE_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic                        ok_now;     // Ready and no paper alarm
    logic                        start_call; // A call turns printing on
    logic                        stop_call;  // A call ends
    logic [ijp_pkg::EV_W-1:0]    ev;         // Events of this cycle
    logic                        new_vld;    // Front end delivers a code
    logic [ijp_pkg::CODE_W-1:0]  new_code;   // Its code
    logic [ijp_pkg::COL_W-1:0]   col_n;      // Column after this cycle
    ok_now     = 1'b0;
    start_call = 1'b0;
    stop_call  = 1'b0;
    ev         = '0;
    new_vld    = 1'b0;
    new_code   = '0;
    col_n      = '0;
    st_d       = st_q;

    // Ready from the interlock string and malfunction inputs
    st_d.ready = interlock_ok_i & paper_thread_ok_i
               & ~hv_fault_i & ~feed_fault_i;
    ok_now     = st_q.ready & ~paper_fault_i;

    // Call starts: carrier edge, data key, or tone under discrete calling
    st_d.carrier_prev = carrier_i;
    start_call = (ok_now & carrier_i & ~st_q.carrier_prev)
               | (st_q.ready & data_key_i)
               | (ok_now & st_q.ctrl[ijp_pkg::C_DISC] & tone_done_i);

    // Carrier-loss timer only runs while printing and carrier is off
    if (carrier_i || !st_q.on) begin
      st_d.disc_cnt = '0;
    end else if (st_q.disc_cnt != DISC_CYC - 1) begin
      st_d.disc_cnt = st_q.disc_cnt + 32'h1;
    end

    // Stop wins over start so a faulty station never comes on
    stop_call = (st_q.on && !carrier_i && st_q.disc_cnt == DISC_CYC - 1)
              | ~st_q.ready | voice_mode_i;
    if (stop_call) begin
      st_d.on = 1'b0;
    end else if (start_call) begin
      st_d.on = 1'b1;
    end
    ev[ijp_pkg::E_ON]    = st_d.on & ~st_q.on;
    ev[ijp_pkg::E_OFF]   = st_q.on & ~st_d.on;
    ev[ijp_pkg::E_FAULT] = st_q.ready & ~st_d.ready;

    // Unattended answer: go off-hook on ring when allowed
    if (stop_call) begin
      st_d.answer = 1'b0;
    end else if (ring_i && auto_answer_i && ok_now) begin
      st_d.answer = 1'b1;
    end

    // Serial front end: start bit, seven data bits LSB first, stop bit
    case (st_q.rx)
      ijp_pkg::RX_IDLE: begin
        if (!serial_front_end_i) begin
          st_d.rx     = ijp_pkg::RX_START;
          st_d.rx_cnt = BIT_CYC / 2;
        end
      end
      ijp_pkg::RX_START: begin
        if (st_q.rx_cnt != 0) begin
          st_d.rx_cnt = st_q.rx_cnt - 32'h1;
        end else if (serial_front_end_i) begin
          st_d.rx = ijp_pkg::RX_IDLE;  // Glitch, not a start bit
        end else begin
          st_d.rx     = ijp_pkg::RX_DATA;
          st_d.rx_cnt = BIT_CYC - 1;
          st_d.rx_bit = '0;
        end
      end
      ijp_pkg::RX_DATA: begin
        if (st_q.rx_cnt != 0) begin
          st_d.rx_cnt = st_q.rx_cnt - 32'h1;
        end else begin
          st_d.rx_sh  = {serial_front_end_i, st_q.rx_sh[ijp_pkg::CODE_W-1:1]};
          st_d.rx_cnt = BIT_CYC - 1;
          st_d.rx_bit = st_q.rx_bit + 3'h1;
          if (st_q.rx_bit == 3'(ijp_pkg::CODE_W - 1)) begin
            st_d.rx = ijp_pkg::RX_STOP;
          end
        end
      end
      ijp_pkg::RX_STOP: begin
        if (st_q.rx_cnt != 0) begin
          st_d.rx_cnt = st_q.rx_cnt - 32'h1;
        end else begin
          st_d.rx = ijp_pkg::RX_IDLE;
          // Framing error drops the character silently
          new_vld = serial_front_end_i & st_q.ctrl[ijp_pkg::C_SER];
          new_code = st_q.rx_sh;
        end
      end
      default: st_d.rx = ijp_pkg::RX_IDLE;
    endcase

    // Parallel front end: strobe carries the seven bits
    if (!st_q.ctrl[ijp_pkg::C_SER]) begin
      new_vld  = par_strobe_i;
      new_code = parallel_front_end_i;
    end

    // Character generator sequencer
    st_d.line_feed = 1'b0;
    col_n          = st_q.column;
    case (st_q.ch)
      ijp_pkg::CH_IDLE: begin
        if (new_vld && st_q.on) begin
          if (new_code == ijp_pkg::LF_CODE) begin
            st_d.line_feed     = 1'b1;
            col_n              = '0;
            ev[ijp_pkg::E_CHAR] = 1'b1;
          end else begin
            st_d.code     = new_code;
            st_d.step     = '0;
            st_d.step_cnt = STEP_CYC - 1;
            st_d.ch       = ijp_pkg::CH_STEP;
          end
        end
      end
      ijp_pkg::CH_STEP: begin
        // Current word drives the tracing outputs for its whole step
        st_d.trace = ijp_pkg::ijp_trace_t'(cmem[{st_q.code, st_q.step}]);
        if (st_q.step_cnt != 0) begin
          st_d.step_cnt = st_q.step_cnt - 32'h1;
        end else if (st_q.step == 3'(ijp_pkg::STEPS - 1)) begin
          st_d.ch = ijp_pkg::CH_SPACE;
        end else begin
          st_d.step     = st_q.step + 3'h1;
          st_d.step_cnt = STEP_CYC - 1;
        end
      end
      ijp_pkg::CH_SPACE: begin
        // Space to next column, wrapping at the right margin
        col_n = (st_q.column == ijp_pkg::COL_LAST) ? '0 : st_q.column + 6'h1;
        st_d.trace          = '0;
        st_d.ch             = ijp_pkg::CH_IDLE;
        ev[ijp_pkg::E_CHAR] = 1'b1;
      end
      default: st_d.ch = ijp_pkg::CH_IDLE;
    endcase
    if (new_vld && st_q.on && st_q.ch != ijp_pkg::CH_IDLE) begin
      ev[ijp_pkg::E_LOST] = 1'b1;  // No buffer: a code while busy is lost
    end
    st_d.column = col_n;

    // Column decode: group one-hot from upper bits, binary from lower
    st_d.col.group = ijp_pkg::GROUPS'(5'h01 << col_n[ijp_pkg::COL_W-1:ijp_pkg::BIN_W]);
    st_d.col.bin   = col_n[ijp_pkg::BIN_W-1:0];
    st_d.col.bin_n = ~col_n[ijp_pkg::BIN_W-1:0];

    // Register writes
    if (wr_i) begin
      case (addr_i)
        ijp_pkg::A_CTRL: st_d.ctrl     = wdata_i[ijp_pkg::CTRL_W-1:0];
        ijp_pkg::A_IRQM: st_d.irq_mask = wdata_i[ijp_pkg::EV_W-1:0];
        ijp_pkg::A_MADR: st_d.mem_adr  = wdata_i[ijp_pkg::MEM_AW-1:0];
        ijp_pkg::A_MDAT: st_d.mem_adr  = st_q.mem_adr + 10'h1;  // Auto-increment
        default: ;
      endcase
    end

    // Sticky events: a set in the clearing cycle wins
    for (int i = 0; i < ijp_pkg::EV_W; i++) begin
      if (ev[i]) begin
        st_d.irq_stat[i] = 1'b1;
      end else if (wr_i && addr_i == ijp_pkg::A_IRQS && wdata_i[i]) begin
        st_d.irq_stat[i] = 1'b0;
      end
    end
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

    // Read data in the cycle after the strobe, zero otherwise
    st_d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        ijp_pkg::A_CTRL: st_d.rdata[ijp_pkg::CTRL_W-1:0] = st_q.ctrl;
        ijp_pkg::A_STAT: st_d.rdata[5:0] = {st_q.ch != ijp_pkg::CH_IDLE, carrier_i,
                                            paper_fault_i, st_q.answer, st_q.on, st_q.ready};
        ijp_pkg::A_IRQS: st_d.rdata[ijp_pkg::EV_W-1:0]   = st_q.irq_stat;
        ijp_pkg::A_IRQM: st_d.rdata[ijp_pkg::EV_W-1:0]   = st_q.irq_mask;
        ijp_pkg::A_MADR: st_d.rdata[ijp_pkg::MEM_AW-1:0] = st_q.mem_adr;
        default: st_d.rdata = '0;  // Unmapped reads as zero
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q      <= '0;
      st_q.ctrl <= ijp_pkg::CTRL_RST;
      st_q.rx   <= ijp_pkg::RX_IDLE;
      st_q.ch   <= ijp_pkg::CH_IDLE;
      st_q.col  <= '{group: 5'h01, bin: 3'h0, bin_n: 3'h7};
      st_q.carrier_prev <= 1'b1;  // A carrier present at reset is no new call
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from state flops
  // ---------------------------------------------------------------------------
  assign rdata_o       = st_q.rdata;
  assign irq_o         = st_q.irq;
  assign ready_o       = st_q.ready;
  assign printing_on_o = st_q.on;
  assign answer_o      = st_q.answer;
  assign motors_o      = st_q.on;   // The four station drives switch as one
  assign hv_on_o       = st_q.on;
  assign on_lamp_o     = st_q.on;
  assign superv_o      = st_q.on;
  assign col_o         = st_q.col;
  assign trace_o       = st_q.trace;
  assign line_feed_o   = st_q.line_feed;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic [31:0] hold_cnt;  // Consecutive stepping cycles
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || st_q.ch != ijp_pkg::CH_STEP) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + 32'h1;
    end
  end

  a_ready_drop_off: assert property (!interlock_ok_i |=> !ready_o ##1 !printing_on_o)
    else $error("ready or printing stayed up with interlock open");
  a_carrier_turn_on: assert property ($rose(carrier_i) && st_q.carrier_prev == 1'b0
      && ready_o && interlock_ok_i && paper_thread_ok_i && !hv_fault_i && !feed_fault_i
      && !paper_fault_i && !voice_mode_i |=> printing_on_o)
    else $error("carrier did not turn printer on");
  a_loss_timeout: assert property (printing_on_o && !carrier_i
      && st_q.disc_cnt == DISC_CYC - 1 |=> !printing_on_o)
    else $error("printer stayed on after carrier loss time");
  a_timer_restart: assert property (carrier_i |=> st_q.disc_cnt == 0)
    else $error("carrier-loss timer not restarted");
  a_fault_refuses: assert property (hv_fault_i ##1 data_key_i |=> !printing_on_o)
    else $error("call accepted during malfunction");
  // A carrier-loss stop in the same cycle beats any start, so that cycle is left out
  a_auto_answer: assert property (ring_i && auto_answer_i && ready_o && !paper_fault_i
      && interlock_ok_i && paper_thread_ok_i && !hv_fault_i && !feed_fault_i
      && !voice_mode_i && st_q.disc_cnt != DISC_CYC - 1 |=> answer_o)
    else $error("unattended call not answered");
  a_key_drives: assert property (data_key_i && ready_o && interlock_ok_i
      && paper_thread_ok_i && !hv_fault_i && !feed_fault_i && !voice_mode_i
      && st_q.disc_cnt != DISC_CYC - 1
      |=> motors_o && hv_on_o && on_lamp_o && superv_o)
    else $error("data key did not start station drives");
  a_tone_data: assert property (tone_done_i && st_q.ctrl[ijp_pkg::C_DISC] && ready_o
      && !paper_fault_i && interlock_ok_i && paper_thread_ok_i && !hv_fault_i
      && !feed_fault_i && !voice_mode_i && st_q.disc_cnt != DISC_CYC - 1
      |=> printing_on_o)
    else $error("tone end did not enter data mode");
  a_hold_length: assert property ($fell(st_q.ch == ijp_pkg::CH_STEP)
      |-> $past(hold_cnt) == STEP_CYC * ijp_pkg::STEPS - 1)
    else $error("character hold length wrong");
  a_space_step: assert property (st_q.ch == ijp_pkg::CH_SPACE
      && st_q.column != ijp_pkg::COL_LAST |=> st_q.column == $past(st_q.column) + 6'h1)
    else $error("column did not advance after character");
  a_lf_path: assert property (line_feed_o |-> st_q.column == 0
      && st_q.ch == ijp_pkg::CH_IDLE && trace_o == $past(trace_o))
    else $error("line feed touched tracing or spacing wrongly");
  a_col_decode: assert property ($onehot(col_o.group) && col_o.bin_n == ~col_o.bin
      && {col_o.group == 5'h10, col_o.bin} <= {1'b1, 3'h7})
    else $error("column select encoding broken");

endmodule

/* File: sim/ijp_modem.sv */
// Modem model: carrier detect and serial frames toward the station
`timescale 1ns/10ps
module ijp_modem #(
  parameter int unsigned BIT_CYC = 16  // Cycles per serial bit
) (
  input  wire logic       clk_sys_i,
  input  wire logic       call_i,      // Carrier wanted
  input  wire logic       go_i,        // Send one frame
  input  wire logic [6:0] code_i,      // Code to send
  output logic            carrier_o,
  output logic            line_o
);
  logic [8:0] frm_q = 9'h1ff;  // Stop, data, start
  int         n_q   = 0;       // Frame cycles left
  // Sender ends a call by holding carrier off
  assign carrier_o = call_i;
  // Idle high, start low, LSB first, stop high
  assign line_o = (n_q != 0) ? frm_q[0] : 1'b1;
  // One bit per BIT_CYC cycles; a busy frame ignores go_i
  always @(posedge clk_sys_i) begin
    if (go_i && n_q == 0) begin
      frm_q <= {1'b1, code_i, 1'b0};
      n_q   <= 9 * BIT_CYC;
    end else if (n_q != 0) begin
      n_q <= n_q - 1;
      if (n_q % BIT_CYC == 1)
        frm_q <= {1'b1, frm_q[8:1]};
    end
  end
endmodule

/* File: sim/tb_ijp_station.sv */
// Self-checking bench for the ink-jet station block
`timescale 1ns/10ps
module tb_ijp_station;
  localparam int unsigned DC = 50;  // Short disconnect count keeps the run brief
  localparam int unsigned BC = 16;  // Short bit time
  logic clk_sys_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, v;
  logic interlock_ok_i = 1'b1, paper_thread_ok_i = 1'b1, hv_fault_i = 1'b0;
  logic feed_fault_i = 1'b0, paper_fault_i = 1'b0, ring_i = 1'b0, auto_answer_i = 1'b0;
  logic data_key_i = 1'b0, voice_mode_i = 1'b0, tone_done_i = 1'b0, par_strobe_i = 1'b0;
  logic call = 1'b0, go = 1'b0, line, carrier, irq_o, ready_o, printing_on_o, answer_o;
  logic motors_o, hv_on_o, on_lamp_o, superv_o, line_feed_o;
  logic [6:0] parallel_front_end_i = 7'h00, c = 7'h00;
  ijp_pkg::ijp_col_t col_o;
  ijp_pkg::ijp_trace_t trace_o;
  logic [9:0] mem [8];  // Trace words loaded for one code
  int failures = 0, n_tests = 0, seed = 42, k, cnt;
  always #50 clk_sys_i = ~clk_sys_i;
  ijp_modem #(.BIT_CYC(BC)) i_modem (.clk_sys_i, .call_i(call), .go_i(go), .code_i(c),
    .carrier_o(carrier), .line_o(line));
  ijp_station #(.DISC_CYC(DC), .HOLD_CYC(64), .BIT_CYC(BC)) i_dut (.clk_sys_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .interlock_ok_i, .paper_thread_ok_i,
    .hv_fault_i, .feed_fault_i, .paper_fault_i, .carrier_i(carrier), .ring_i,
    .auto_answer_i, .data_key_i, .voice_mode_i, .tone_done_i, .ready_o, .printing_on_o,
    .answer_o, .motors_o, .hv_on_o, .on_lamp_o, .superv_o, .serial_front_end_i(line),
    .parallel_front_end_i, .par_strobe_i, .col_o, .trace_o, .line_feed_o);
  // ----
  // Helpers
  // ----
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Land just after an edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic pstb(input logic [6:0] x);
    @(posedge clk_sys_i);
    parallel_front_end_i <= x;
    par_strobe_i <= 1'b1;
    @(posedge clk_sys_i);
    par_strobe_i <= 1'b0;
    #1;
  endtask
  // One-cycle pulse on voice, tone or data key
  task automatic pls(input logic [2:0] m);
    @(posedge clk_sys_i);
    {voice_mode_i, tone_done_i, data_key_i} <= m;
    @(posedge clk_sys_i);
    {voice_mode_i, tone_done_i, data_key_i} <= 3'h0;
    cyc(2);
  endtask
  task automatic carr(input logic lvl, input int n);
    @(posedge clk_sys_i);
    call <= lvl;
    cyc(n);
  endtask
  // Bounded wait; serial timing is not pinned to the cycle
  task automatic wait_trace(input logic [9:0] w);
    int i;
    for (i = 0; i < 2000 && trace_o !== w; i++)
      cyc(1);
    if (i == 2000) begin
      failures++;
      summarize();
    end
  endtask
  // Group one-hot of column/8, binary and complement of column%8
  function automatic logic [10:0] colx(input int n);
    return {5'(1 << (n / 8)), 3'(n % 8), ~3'(n % 8)};
  endfunction
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cyc(2);
    chk("ready", ready_o, 1'b1);
    chk("reset col", col_o, colx(0));
    wr(ijp_pkg::A_IRQM, 32'h8);
    rd(8'h3c);
    chk("unmapped", v, 32'h0);
    rd(ijp_pkg::A_IRQM);
    chk("mask", v, 32'h8);
    // Each fault source in turn drops ready and refuses a call
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      {interlock_ok_i, paper_thread_ok_i, hv_fault_i, feed_fault_i} <= 4'hc ^ (4'h8 >> k);
      carr(1'b1, 4);
      pls(3'h1);  // Data key during a fault must be refused too
      chk("fault ready", ready_o, 1'b0);
      chk("fault on", printing_on_o, 1'b0);
      @(posedge clk_sys_i);
      {interlock_ok_i, paper_thread_ok_i, hv_fault_i, feed_fault_i} <= 4'hc;
      carr(1'b0, 3);
    end
    carr(1'b1, 3);
    chk("on", {printing_on_o, motors_o, hv_on_o, on_lamp_o, superv_o}, 5'h1f);
    chk("masked irq", irq_o, 1'b0);
    rd(ijp_pkg::A_STAT);
    chk("status", v, 32'h13);
    c = 7'h20 + 7'($random(seed) & 32'h3f);
    wr(ijp_pkg::A_MADR, {c, 3'h0});
    for (k = 0; k < 8; k++) begin
      mem[k] = (k == 0) ? 10'h3ff : 10'($random(seed));  // Corner: first word never zero
      wr(ijp_pkg::A_MDAT, mem[k]);
    end
    pstb(c);
    cyc(3);
    for (k = 0; k < 8; k++) begin
      chk("trace", trace_o, mem[k]);
      cyc(8);
    end
    cyc(3);
    chk("space col", col_o, colx(1));
    chk("space trace", trace_o, 10'h0);
    chk("char irq", irq_o, 1'b1);
    wr(ijp_pkg::A_IRQS, 32'h1f);
    cyc(2);
    chk("cleared irq", irq_o, 1'b0);
    pstb(ijp_pkg::LF_CODE);
    cnt = 0;
    for (k = 0; k < 5; k++) begin
      cnt += line_feed_o;
      cyc(1);
    end
    chk("lf pulses", cnt, 32'h1);
    chk("lf col", col_o, colx(0));
    chk("lf trace", trace_o, 10'h0);
    wr(ijp_pkg::A_CTRL, 32'h1);
    @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    wait_trace(mem[0]);
    cyc(80);
    chk("serial col", col_o, colx(1));
    // Short carrier return restarts the loss timer
    carr(1'b0, DC - 5);
    carr(1'b1, 2);
    carr(1'b0, DC - 5);
    chk("timer restart", printing_on_o, 1'b1);
    cyc(10);
    chk("carrier loss", printing_on_o, 1'b0);
    pls(3'h1);
    chk("data key", {motors_o, superv_o}, 2'h3);
    pls(3'h4);
    chk("voice off", printing_on_o, 1'b0);
    wr(ijp_pkg::A_CTRL, 32'h2);
    pls(3'h2);
    chk("tone", printing_on_o, 1'b1);
    @(posedge clk_sys_i);
    {paper_fault_i, ring_i, auto_answer_i} <= 3'h7;
    cyc(3);
    chk("answer refused", answer_o, 1'b0);
    @(posedge clk_sys_i);
    paper_fault_i <= 1'b0;
    cyc(3);
    chk("answer", answer_o, 1'b1);
    summarize();
  end
endmodule
